// file: hw/los_consts.svh
// constants for the link oam sublayer: timing, addresses, event bit positions
// assumes a single 50 MHz port clock
`ifndef LOS_CONSTS_SVH
`define LOS_CONSTS_SVH
// ********************
// timing
// ********************
`define LOS_CLK_HZ        50_000_000
`define LOS_MAX_PDU_PER_S 10
`define LOS_LINK_TMO_S    5
`define LOS_SEC_S         1
// ********************
// addressing and widths
// ********************
`define LOS_SLOW_DA       48'h0180C2000002
`define LOS_THR_W         16
`define LOS_WIN_W         8
`define LOS_EVT_SYM       0
`define LOS_EVT_FPER      1
`define LOS_EVT_FRM       2
`define LOS_EVT_FSEC      3
`endif

// file: hw/los_pkg.sv
// types shared by the link oam sublayer
// assumes los_consts.svh is on the include path
`include "los_consts.svh"
package los_pkg;
   // ********************
   // pdu kinds and session states
   // ********************
   typedef enum logic [2:0] {
      LOS_PDU_INFO   = 3'h0,
      LOS_PDU_EVENT  = 3'h1,
      LOS_PDU_LB_REQ = 3'h2,
      LOS_PDU_LB_ACK = 3'h3,
      LOS_PDU_LB_END = 3'h4
   } los_kind_t;
   typedef enum logic [1:0] {
      LOS_ST_OFF  = 2'b00,
      LOS_ST_WAIT = 2'b01,
      LOS_ST_DISC = 2'b10,
      LOS_ST_UP   = 2'b11
   } los_state_t;
   // ********************
   // carriers
   // ********************
   typedef struct packed {
      logic dying_gasp;
      logic crit;
      logic link_fault;
   } los_flags_t;
   typedef struct packed {
      logic       valid;
      los_kind_t  kind;
      los_flags_t flags;
      logic [3:0] evt;
      logic [47:0] da;
   } los_pdu_t;
   typedef struct packed {
      logic       valid;
      logic       is_oam;
      logic       last;
      logic [7:0] data;
   } los_frm_t;
endpackage

// file: hw/los_core.sv
// link oam sublayer for one point-to-point port: discovery, keepalive,
// link monitoring, fault flags and remote loopback
// assumes a pdu framer/parser outside; all inputs synchronous to clk
//
// What this block does
// - sent oam pdus carry destination 01-80-c2-00-00-02
// - at most ten oam pdus per second
// - session setup only by exchanging information pdus
// - only active mode initiates; passive waits
// - in session, keep sending information pdus
// - drop session after five silent seconds
// - link event sends notification and pulses management indication
// - record and report peer event notifications
// - symbol period event when errored symbols reach low threshold
// - frame period event when crc errors in n frames reach threshold
// - frame event when errored frames in m seconds reach threshold
// - frame seconds event when errored seconds in m seconds reach threshold
// - faults travel in the flag field of information pdus
// - critical-event flag while oam is disabled
// - link-fault flag when unidirectional faults reach high threshold
// - never originate dying gasp, but accept one from the peer
// - refuse remote loopback until session is up
// - only active mode requests loopback; answer peer requests
// - in loopback return received non-oam frames to sender
// - suspend user forwarding while loopback is active
// - active mode after reset unless configured passive
`timescale 1ns/1ps
`include "los_consts.svh"
module los_core #(
   parameter int unsigned GAP_CYC = `LOS_CLK_HZ / `LOS_MAX_PDU_PER_S,  // least pdu spacing
   parameter int unsigned TMO_CYC = `LOS_LINK_TMO_S * `LOS_CLK_HZ,     // keepalive timeout
   parameter int unsigned SEC_CYC = `LOS_SEC_S * `LOS_CLK_HZ           // one second
) (
   input  wire logic                  clk,           // port clock
   input  wire logic                  rst_b,         // sync reset, low
   input  wire logic                  oam_en,        // oam enabled on port
   input  wire logic                  passive_mode,  // 1 = passive mode
   input  wire logic                  lb_start,      // mgmt loopback request pulse
   input  wire logic                  lb_stop,       // mgmt loopback end pulse
   input  wire logic [`LOS_THR_W-1:0] sym_thr,       // symbol low threshold
   input  wire logic [`LOS_WIN_W-1:0] sym_win_s,     // symbol window, seconds
   input  wire logic [`LOS_THR_W-1:0] fper_thr,      // frame period low threshold
   input  wire logic [`LOS_THR_W-1:0] fper_n,        // frame period length n
   input  wire logic [`LOS_THR_W-1:0] frm_thr,       // errored frame low threshold
   input  wire logic [`LOS_WIN_W-1:0] frm_win_s,     // errored frame window m
   input  wire logic [`LOS_THR_W-1:0] fsec_thr,      // errored seconds low threshold
   input  wire logic [`LOS_WIN_W-1:0] fsec_win_s,    // errored seconds window m
   input  wire logic [`LOS_THR_W-1:0] uni_thr,       // unidirectional high threshold
   input  wire logic                  sym_err,       // errored symbol pulse
   input  wire logic                  frm_rx,        // frame received pulse
   input  wire logic                  frm_crc_err,   // with frm_rx: crc bad
   input  wire logic                  uni_fault,     // unidirectional fault pulse
   input  wire los_pkg::los_pdu_t     rx_pdu,        // parsed received pdu
   output los_pkg::los_pdu_t          tx_pdu,        // pdu to framer, held till tx_rdy
   input  wire logic                  tx_rdy,        // framer takes tx_pdu
   input  wire los_pkg::los_frm_t     rx_frm,        // received frame bytes
   output los_pkg::los_frm_t          lb_frm,        // looped-back bytes to link
   output los_pkg::los_frm_t          fwd_frm,       // bytes forwarded to switch
   output logic                       session_up,    // session established
   output logic                       lb_active,     // this end loops frames
   output logic                       lb_remote,     // peer is looping for us
   output logic                       lb_refused,    // loopback refused pulse
   output logic [3:0]                 evt_ind,       // local event pulses
   output logic                       peer_evt,      // peer event pulse
   output logic [15:0]                peer_evt_cnt,  // peer events recorded
   output los_pkg::los_flags_t        loc_flags,     // local fault flags
   output los_pkg::los_flags_t        peer_flags     // last peer flags
);
   los_pkg::los_state_t st_r, st_nxt;
   los_pkg::los_pdu_t   tx_r;
   los_pkg::los_frm_t   lb_r, fwd_r;
   los_pkg::los_flags_t lf_r, pf_r;
   logic [31:0]         gap_r, tmo_r, sec_r;
   logic                tick;
   logic                rx_info, rx_lbq, rx_lba, rx_lbe, rx_evt;
   logic                lbact_r, lbrem_r, lbref_r, lbq_pend_r, lba_pend_r, lbe_pend_r;
   logic [3:0]          evt_r, evt_pend_r, evt_hit;
   logic                pevt_r;
   logic [15:0]         pcnt_r;
   logic [`LOS_THR_W-1:0] sym_c_r, fper_c_r, fper_f_r, frm_c_r, fsec_c_r, uni_c_r;
   logic [`LOS_WIN_W-1:0] sym_w_r, frm_w_r, fsec_w_r;
   logic                sec_err_r;
   logic                sym_end, fper_end, frm_end, fsec_end;
   logic                send_ok;

   // ********************
   // decode of received pdus
   // ********************
   assign rx_info = rx_pdu.valid && rx_pdu.kind == los_pkg::LOS_PDU_INFO;
   assign rx_evt  = rx_pdu.valid && rx_pdu.kind == los_pkg::LOS_PDU_EVENT;
   assign rx_lbq  = rx_pdu.valid && rx_pdu.kind == los_pkg::LOS_PDU_LB_REQ;
   assign rx_lba  = rx_pdu.valid && rx_pdu.kind == los_pkg::LOS_PDU_LB_ACK;
   assign rx_lbe  = rx_pdu.valid && rx_pdu.kind == los_pkg::LOS_PDU_LB_END;

   // ********************
   // session state machine
   // ********************
   // discovery start point chosen by mode
   always_comb begin
      st_nxt = st_r;
      case (st_r)
         los_pkg::LOS_ST_OFF: begin
            if (oam_en)
               st_nxt = passive_mode ? los_pkg::LOS_ST_WAIT : los_pkg::LOS_ST_DISC;
         end
         los_pkg::LOS_ST_WAIT: begin
            if (rx_info)
               st_nxt = los_pkg::LOS_ST_UP;
         end
         los_pkg::LOS_ST_DISC: begin
            if (rx_info)
               st_nxt = los_pkg::LOS_ST_UP;
         end
         los_pkg::LOS_ST_UP: begin
            if (tmo_r >= TMO_CYC - 1 && !rx_info)
               st_nxt = passive_mode ? los_pkg::LOS_ST_WAIT : los_pkg::LOS_ST_DISC;
         end
         default: st_nxt = los_pkg::LOS_ST_OFF;
      endcase
      if (!oam_en)
         st_nxt = los_pkg::LOS_ST_OFF;
   end

   always_ff @(posedge clk) begin
      if (!rst_b)
         st_r <= los_pkg::LOS_ST_OFF;
      else
         st_r <= st_nxt;
   end

   // silence timer, restarted by every information pdu
   always_ff @(posedge clk) begin
      if (!rst_b || st_r != los_pkg::LOS_ST_UP || rx_info)
         tmo_r <= 32'h0;
      else
         tmo_r <= tmo_r + 32'h1;
   end

   // ********************
   // transmit scheduling
   // ********************
   // spacing counter caps the pdu rate
   always_ff @(posedge clk) begin
      if (!rst_b)
         gap_r <= 32'h0;
      else if (tx_r.valid && tx_rdy)
         gap_r <= GAP_CYC - 1;
      else if (gap_r != 32'h0)
         gap_r <= gap_r - 32'h1;
   end

   assign send_ok = !tx_r.valid && gap_r == 32'h0
                    && (st_r == los_pkg::LOS_ST_DISC || st_r == los_pkg::LOS_ST_UP
                        || (st_r == los_pkg::LOS_ST_WAIT && rx_info));

   // loopback answers first, then loopback requests and ends, then events, else the keepalive
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         tx_r <= '0;
      end else if (tx_r.valid) begin
         if (tx_rdy)
            tx_r.valid <= 1'b0;
      end else if (send_ok) begin
         tx_r.valid <= 1'b1;
         tx_r.da    <= `LOS_SLOW_DA;
         tx_r.flags <= lf_r;
         tx_r.evt   <= 4'h0;
         if (lba_pend_r)
            tx_r.kind <= los_pkg::LOS_PDU_LB_ACK;
         else if (lbq_pend_r)
            tx_r.kind <= los_pkg::LOS_PDU_LB_REQ;
         else if (lbe_pend_r)
            tx_r.kind <= los_pkg::LOS_PDU_LB_END;
         else if (evt_pend_r != 4'h0 && st_r == los_pkg::LOS_ST_UP) begin
            tx_r.kind <= los_pkg::LOS_PDU_EVENT;
            tx_r.evt  <= evt_pend_r;
         end else
            tx_r.kind <= los_pkg::LOS_PDU_INFO;
      end
   end

   // ********************
   // local fault flags
   // ********************
   // dying gasp is never raised here; the count saturates
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lf_r    <= '0;
         uni_c_r <= '0;
      end else begin
         lf_r.dying_gasp <= 1'b0;
         lf_r.crit       <= !oam_en;
         if (!oam_en)
            uni_c_r <= '0;
         else if (uni_fault && uni_c_r != '1)
            uni_c_r <= uni_c_r + 1'b1;
         lf_r.link_fault <= oam_en && uni_c_r >= uni_thr;
      end
   end

   // ********************
   // peer records
   // ********************
   // peer flags kept as last seen, dying gasp included
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         pf_r   <= '0;
         pevt_r <= 1'b0;
         pcnt_r <= 16'h0;
      end else begin
         if (rx_info)
            pf_r <= rx_pdu.flags;
         pevt_r <= rx_evt && st_r == los_pkg::LOS_ST_UP;
         if (rx_evt && st_r == los_pkg::LOS_ST_UP && pcnt_r != 16'hFFFF)
            pcnt_r <= pcnt_r + 16'h1;
      end
   end

   // ********************
   // link monitoring
   // ********************
   // one-second tick shared by the windowed monitors
   always_ff @(posedge clk) begin
      if (!rst_b || sec_r >= SEC_CYC - 1)
         sec_r <= 32'h0;
      else
         sec_r <= sec_r + 32'h1;
   end
   assign tick = sec_r >= SEC_CYC - 1;

   assign sym_end  = tick && sym_w_r + 1'b1 >= sym_win_s;
   assign frm_end  = tick && frm_w_r + 1'b1 >= frm_win_s;
   assign fsec_end = tick && fsec_w_r + 1'b1 >= fsec_win_s;
   assign fper_end = frm_rx && fper_f_r + 1'b1 >= fper_n;

   // counters clear at window end; last-cycle hits count
   always_ff @(posedge clk) begin
      if (!rst_b || !oam_en) begin
         sym_c_r  <= '0;
         sym_w_r  <= '0;
         fper_c_r <= '0;
         fper_f_r <= '0;
         frm_c_r  <= '0;
         frm_w_r  <= '0;
         fsec_c_r <= '0;
         fsec_w_r <= '0;
         sec_err_r <= 1'b0;
      end else begin
         sym_w_r  <= sym_end ? '0 : sym_w_r + {7'h0, tick};
         sym_c_r  <= sym_end ? '0 : sym_c_r + {15'h0, sym_err && sym_c_r != '1};
         fper_f_r <= fper_end ? '0 : fper_f_r + {15'h0, frm_rx};
         fper_c_r <= fper_end ? '0 : fper_c_r + {15'h0, frm_rx && frm_crc_err};
         frm_w_r  <= frm_end ? '0 : frm_w_r + {7'h0, tick};
         frm_c_r  <= frm_end ? '0 : frm_c_r + {15'h0, frm_rx && frm_crc_err && frm_c_r != '1};
         sec_err_r <= tick ? 1'b0 : (sec_err_r || (frm_rx && frm_crc_err));
         fsec_w_r <= fsec_end ? '0 : fsec_w_r + {7'h0, tick};
         fsec_c_r <= fsec_end ? '0 : fsec_c_r + {15'h0, tick && sec_err_r};
      end
   end

   // threshold test on the closing window count
   always_comb begin
      evt_hit = 4'h0;
      evt_hit[`LOS_EVT_SYM]  = sym_end && sym_c_r + {15'h0, sym_err} >= sym_thr;
      evt_hit[`LOS_EVT_FPER] = fper_end && fper_c_r + {15'h0, frm_crc_err} >= fper_thr;
      evt_hit[`LOS_EVT_FRM]  = frm_end && frm_c_r + {15'h0, frm_rx && frm_crc_err} >= frm_thr;
      evt_hit[`LOS_EVT_FSEC] = fsec_end && fsec_c_r + {15'h0, sec_err_r} >= fsec_thr;
   end

   // pending events: a new hit wins over the send clear
   always_ff @(posedge clk) begin
      if (!rst_b || !oam_en) begin
         evt_r      <= 4'h0;
         evt_pend_r <= 4'h0;
      end else begin
         evt_r <= evt_hit;
         if (send_ok && !lba_pend_r && !lbq_pend_r && !lbe_pend_r
             && st_r == los_pkg::LOS_ST_UP)
            evt_pend_r <= evt_hit;
         else
            evt_pend_r <= evt_pend_r | evt_hit;
      end
   end

   // ********************
   // remote loopback control
   // ********************
   // requests only from an active end with a session up
   always_ff @(posedge clk) begin
      if (!rst_b || !oam_en || st_r != los_pkg::LOS_ST_UP) begin
         lbact_r    <= 1'b0;
         lbrem_r    <= 1'b0;
         lbq_pend_r <= 1'b0;
         lba_pend_r <= 1'b0;
         lbe_pend_r <= 1'b0;
         lbref_r    <= rst_b && lb_start;
      end else begin
         lbref_r <= lb_start && passive_mode;
         if (lb_start && !passive_mode && !lbrem_r)
            lbq_pend_r <= 1'b1;
         else if (send_ok && !lba_pend_r)
            lbq_pend_r <= 1'b0;
         if (rx_lbq) begin
            lba_pend_r <= 1'b1;
            lbact_r    <= 1'b1;
         end else if (send_ok)
            lba_pend_r <= 1'b0;
         if (rx_lba)
            lbrem_r <= 1'b1;
         if (lb_stop && lbrem_r) begin
            lbe_pend_r <= 1'b1;
            lbrem_r    <= 1'b0;
         end else if (send_ok && !lba_pend_r && !lbq_pend_r)
            lbe_pend_r <= 1'b0;
         if (rx_lbe)
            lbact_r <= 1'b0;
      end
   end

   // ********************
   // frame path
   // ********************
   // oam pdus never loop; user traffic stops while either end loops
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         lb_r  <= '0;
         fwd_r <= '0;
      end else begin
         lb_r        <= rx_frm;
         lb_r.valid  <= rx_frm.valid && !rx_frm.is_oam && lbact_r;
         fwd_r       <= rx_frm;
         fwd_r.valid <= rx_frm.valid && !rx_frm.is_oam && !lbact_r && !lbrem_r;
      end
   end

   // ********************
   // outputs
   // ********************
   always_ff @(posedge clk) begin
      if (!rst_b)
         session_up <= 1'b0;
      else
         session_up <= st_nxt == los_pkg::LOS_ST_UP;
   end
   assign tx_pdu       = tx_r;
   assign lb_frm       = lb_r;
   assign fwd_frm      = fwd_r;
   assign lb_active    = lbact_r;
   assign lb_remote    = lbrem_r;
   assign lb_refused   = lbref_r;
   assign evt_ind      = evt_r;
   assign peer_evt     = pevt_r;
   assign peer_evt_cnt = pcnt_r;
   assign loc_flags    = lf_r;
   assign peer_flags   = pf_r;
endmodule

// file: tb/los_core_assertions.sv
// assertions on los_core ports: pdu address and spacing, session,
// fault flags and loopback; assumes bind with the core's parameters
`timescale 1ns/1ps
module los_core_assertions #(
   parameter int unsigned GAP_CYC = 20,   // least pdu spacing
   parameter int unsigned TMO_CYC = 200,  // keepalive timeout
   parameter int unsigned SEC_CYC = 50    // one second
) (
   input wire logic                clk,           // clock
   input wire logic                rst_b,         // sync reset
   input wire logic                oam_en,        // oam on
   input wire logic                passive_mode,  // passive
   input wire logic                lb_start,      // loop request
   input wire los_pkg::los_pdu_t   rx_pdu,        // peer pdu
   input wire los_pkg::los_pdu_t   tx_pdu,        // sent pdu
   input wire logic                tx_rdy,        // framer take
   input wire los_pkg::los_frm_t   rx_frm,        // rx bytes
   input wire los_pkg::los_frm_t   lb_frm,        // looped bytes
   input wire los_pkg::los_frm_t   fwd_frm,       // fwd bytes
   input wire logic                session_up,    // session
   input wire logic                lb_active,     // we loop
   input wire logic                lb_remote,     // peer loops
   input wire logic                lb_refused,    // refusal
   input wire logic                peer_evt,      // peer event
   input wire los_pkg::los_flags_t loc_flags      // own flags
);
   int unsigned gap_n;    // cycles since a pdu was taken
   int unsigned quiet_n;  // cycles since peer info came
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   // spacing counter, saturates so a long idle never wraps
   always_ff @(posedge clk) begin
      if (!rst_b) gap_n <= GAP_CYC;
      else if (tx_pdu.valid && tx_rdy) gap_n <= 0;
      else if (gap_n < GAP_CYC) gap_n <= gap_n + 1;
   end
   // keepalive silence counter
   always_ff @(posedge clk) begin
      if (!rst_b || (rx_pdu.valid && rx_pdu.kind == los_pkg::LOS_PDU_INFO)) quiet_n <= 0;
      else if (quiet_n < TMO_CYC + 4) quiet_n <= quiet_n + 1;
   end
   a_tx_dest_addr: assert property (tx_pdu.valid |-> tx_pdu.da == 48'h0180C2000002)
      else $error("bad destination");
   a_tx_rate_gap: assert property ($rose(tx_pdu.valid) |-> gap_n >= GAP_CYC - 1)
      else $error("pdus too close");
   a_tx_hold_req: assert property (tx_pdu.valid && !tx_rdy |=> $stable(tx_pdu))
      else $error("pdu not held");
   a_passive_quiet: assert property (passive_mode && !session_up |-> !$rose(tx_pdu.valid))
      else $error("passive end spoke first");
   a_info_opens: assert property (oam_en [*3] ##0 (rx_pdu.valid && rx_pdu.kind == los_pkg::LOS_PDU_INFO)
      |=> session_up)
      else $error("session not opened");
   a_tmo_drop: assert property (quiet_n >= TMO_CYC + 2 |-> !session_up)
      else $error("no timeout drop");
   a_off_crit: assert property (!oam_en |=> loc_flags.crit && !session_up && !lb_active)
      else $error("disable not seen");
   a_no_gasp: assert property (!loc_flags.dying_gasp && !(tx_pdu.valid && tx_pdu.flags.dying_gasp))
      else $error("dying gasp originated");
   a_lb_refuse: assert property (lb_start && (!session_up || passive_mode) |=> lb_refused)
      else $error("loopback not refused");
   a_lb_echo: assert property (lb_active && $past(lb_active) && $past(rx_frm.valid)
      |-> lb_frm.valid == !$past(rx_frm.is_oam) && lb_frm.data == $past(rx_frm.data))
      else $error("loopback byte wrong");
   a_fwd_held: assert property ((lb_active || lb_remote) && $past(lb_active || lb_remote) |-> !fwd_frm.valid)
      else $error("forward in loopback");
   a_peer_evt_seen: assert property (session_up && rx_pdu.valid && rx_pdu.kind == los_pkg::LOS_PDU_EVENT
      |=> peer_evt)
      else $error("peer event lost");
endmodule
bind los_core los_core_assertions #(.GAP_CYC(GAP_CYC), .TMO_CYC(TMO_CYC), .SEC_CYC(SEC_CYC)) chk_u (
   .clk(clk), .rst_b(rst_b), .oam_en(oam_en), .passive_mode(passive_mode), .lb_start(lb_start),
   .rx_pdu(rx_pdu), .tx_pdu(tx_pdu), .tx_rdy(tx_rdy), .rx_frm(rx_frm), .lb_frm(lb_frm), .fwd_frm(fwd_frm),
   .session_up(session_up), .lb_active(lb_active), .lb_remote(lb_remote), .lb_refused(lb_refused),
   .peer_evt(peer_evt), .loc_flags(loc_flags));

// file: tb/los_peer_model.sv
// peer oam entity and pdu framer for the device's pdus
// assumes the bench sets info_en, slow and flg and queues pdus in q
`timescale 1ns/1ps
`include "los_consts.svh"
module los_peer_model (
   input  wire logic              clk,     // port clock
   input  wire los_pkg::los_pdu_t tx_pdu,  // pdu from device
   output los_pkg::los_pdu_t      rx_pdu,  // pdu to device
   output logic                   tx_rdy   // framer takes pdu
);
   logic                info_en  = 1'h0;           // keepalive on
   logic                slow     = 1'h0;           // framer stalls
   los_pkg::los_flags_t flg      = '0;             // our info flags
   los_pkg::los_flags_t last_flg = '0;             // device info flags
   logic [3:0]          evt_or   = 4'h0;           // event bits seen
   int                  cnt[8]   = '{default: 0};  // taken pdus by kind
   int                  tk       = 0;              // keepalive phase
   los_pkg::los_pdu_t   q[$];                      // pdus to send
   initial rx_pdu = '0;
   initial tx_rdy = 1'h0;
   function automatic los_pkg::los_pdu_t mk(los_pkg::los_kind_t k, los_pkg::los_flags_t f);
      return '{valid: 1'h1, kind: k, flags: f, evt: 4'h0, da: `LOS_SLOW_DA};
   endfunction
   // keepalive every 60 cycles, well under the rate cap; idle shows inverted last pdu
   always @(negedge clk) begin
      tk = (tk == 59) ? 0 : tk + 1;
      if (q.size() != 0) rx_pdu <= q.pop_front();
      else if (info_en && tk == 0) rx_pdu <= mk(los_pkg::LOS_PDU_INFO, flg);
      else rx_pdu <= {1'h0, ~rx_pdu[57:0]};
   end
   // framer accept: stalls three cycles in four when slow
   always @(negedge clk) tx_rdy <= !slow || tk[1:0] == 2'h3;
   // log taken pdus; a loopback request is always answered
   always @(posedge clk) begin
      if (tx_pdu.valid && tx_rdy) begin
         cnt[tx_pdu.kind]++;
         if (tx_pdu.kind == los_pkg::LOS_PDU_INFO) last_flg <= tx_pdu.flags;
         if (tx_pdu.kind == los_pkg::LOS_PDU_EVENT) evt_or <= evt_or | tx_pdu.evt;
         if (tx_pdu.kind == los_pkg::LOS_PDU_LB_REQ) q.push_back(mk(los_pkg::LOS_PDU_LB_ACK, flg));
      end
   end
endmodule

// file: tb/test_link_oam_sublayer.sv
// bench for los_core with the peer model on the pdu side
// inputs change on the falling edge; timing parameters cut down
`timescale 1ns/1ps
module test_link_oam_sublayer;
   logic clk = 1'h0, rst_b = 1'h0, oam_en = 1'h1, passive_mode = 1'h0, lb_start = 1'h0, lb_stop = 1'h0;
   logic sym_err = 1'h0, frm_rx = 1'h0, frm_crc_err = 1'h0, uni_fault = 1'h0;
   logic [15:0] sym_thr = 16'h3, fper_thr = 16'h2, fper_n = 16'h4, frm_thr = 16'h2, fsec_thr = 16'h1;
   logic [15:0] uni_thr = 16'h2, peer_evt_cnt;
   logic [7:0] sym_win_s = 8'h1, frm_win_s = 8'h1, fsec_win_s = 8'h1;
   logic tx_rdy, session_up, lb_active, lb_remote, lb_refused, peer_evt;
   logic [3:0] evt_ind, seen;
   los_pkg::los_pdu_t rx_pdu, tx_pdu;
   los_pkg::los_frm_t rx_frm = '0, lb_frm, fwd_frm;
   los_pkg::los_flags_t loc_flags, peer_flags;
   int n_mismatch = 0, compares = 0, cyc = 0, i, n;
   los_core #(.GAP_CYC(20), .TMO_CYC(200), .SEC_CYC(50)) dut_u (.clk, .rst_b, .oam_en, .passive_mode,
      .lb_start, .lb_stop, .sym_thr, .sym_win_s, .fper_thr, .fper_n, .frm_thr, .frm_win_s, .fsec_thr,
      .fsec_win_s, .uni_thr, .sym_err, .frm_rx, .frm_crc_err, .uni_fault, .rx_pdu, .tx_pdu, .tx_rdy,
      .rx_frm, .lb_frm, .fwd_frm, .session_up, .lb_active, .lb_remote, .lb_refused, .evt_ind, .peer_evt,
      .peer_evt_cnt, .loc_flags, .peer_flags);
   los_peer_model peer_u (.clk, .tx_pdu, .rx_pdu, .tx_rdy);
   // 50 MHz clock and a hang guard well above the expected run
   always #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         finish_test();
      end
   end
   task automatic chk(input logic [47:0] s, input logic [47:0] e);
      compares++;
      if (s !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t: seen %0h expected %0h", $time, s, e);
      end
   endtask
   task automatic tick(input int k);
      repeat (k) @(negedge clk);
   endtask
   // gather event pulses while time passes
   task automatic watch(input int k);
      repeat (k) begin
         @(negedge clk);
         seen |= evt_ind;
      end
   endtask
   // f high: n crc-bad frames, else n errored symbols
   task automatic burst(input int k, input logic f);
      repeat (k) begin
         {sym_err, frm_rx, frm_crc_err} = {!f, f, f};
         watch(1);
         {sym_err, frm_rx, frm_crc_err} = 3'h0;
         watch(1);
      end
   endtask
   // one byte in; released lines show the inverted byte
   task automatic byte_in(input logic [7:0] d, input logic oam);
      rx_frm = '{valid: 1'h1, is_oam: oam, last: 1'h1, data: d};
      tick(1);
      rx_frm = {1'h0, ~rx_frm[9:0]};
   endtask
   task automatic lb_try(input logic e);
      seen = 4'h0;
      lb_start = 1'h1;
      tick(1);
      lb_start = 1'h0;
      repeat (3) begin
         seen[0] |= lb_refused;
         tick(1);
      end
      chk(seen[0], e);
   endtask
   task automatic t_session();
      chk(loc_flags, 3'h0);
      for (i = 0; i < 40 && peer_u.cnt[0] == 0; i++) tick(1);
      chk(peer_u.cnt[0] != 0, 1'h1);
      peer_u.info_en = 1'h1;
      for (i = 0; i < 100 && !session_up; i++) tick(1);
      chk(session_up, 1'h1);
      n = peer_u.cnt[0];
      peer_u.slow = 1'h1;
      tick(120);
      peer_u.slow = 1'h0;
      chk(peer_u.cnt[0] > n + 2, 1'h1);
      $display("%0t session done", $time);
   endtask
   task automatic t_events();
      seen = 4'h0;
      burst(6, 1'h0);
      burst(8, 1'h1);
      watch(130);
      chk(seen, 4'hF);
      for (i = 0; i < 60 && peer_u.evt_or !== 4'hF; i++) tick(1);
      chk(peer_u.evt_or, 4'hF);
      seen = 4'h0;
      burst(2, 1'h0);
      watch(60);
      burst(2, 1'h0);
      watch(130);
      chk(seen, 4'h0);
      $display("%0t events done", $time);
   endtask
   task automatic t_flags();
      n = peer_evt_cnt;
      peer_u.q.push_back(peer_u.mk(los_pkg::LOS_PDU_EVENT, 3'h0));
      tick(4);
      chk(peer_evt_cnt, n + 1);
      peer_u.flg = 3'h4;
      uni_fault = 1'h1;
      tick(1);
      uni_fault = 1'h0;
      tick(2);
      chk(loc_flags.link_fault, 1'h0);
      uni_fault = 1'h1;
      tick(1);
      uni_fault = 1'h0;
      tick(70);
      chk(loc_flags, 3'h1);
      chk(peer_flags, 3'h4);
      chk(peer_u.last_flg, 3'h1);
      peer_u.flg = 3'h0;
      $display("%0t flags done", $time);
   endtask
   task automatic t_loop();
      lb_try(1'h0);
      for (i = 0; i < 60 && !lb_remote; i++) tick(1);
      chk(lb_remote, 1'h1);
      byte_in(8'hA5, 1'h0);
      chk(fwd_frm.valid, 1'h0);
      lb_stop = 1'h1;
      tick(1);
      lb_stop = 1'h0;
      tick(3);
      byte_in(8'hA5, 1'h0);
      chk({lb_remote, fwd_frm.valid, fwd_frm.data}, 10'h1A5);
      n = peer_u.cnt[3];
      peer_u.q.push_back(peer_u.mk(los_pkg::LOS_PDU_LB_REQ, 3'h0));
      for (i = 0; i < 60 && peer_u.cnt[3] == n; i++) tick(1);
      chk({lb_active, peer_u.cnt[3] > n}, 2'h3);
      byte_in(8'h3C, 1'h0);
      chk({lb_frm.valid, lb_frm.data, fwd_frm.valid}, 10'h278);
      byte_in(8'h55, 1'h1);
      chk(lb_frm.valid, 1'h0);
      peer_u.q.push_back(peer_u.mk(los_pkg::LOS_PDU_LB_END, 3'h0));
      tick(4);
      chk(lb_active, 1'h0);
      $display("%0t loopback done", $time);
   endtask
   task automatic t_down();
      peer_u.info_en = 1'h0;
      for (i = 0; i < 320 && session_up; i++) tick(1);
      chk({session_up, i >= 140}, 2'h1);
      lb_try(1'h1);
      oam_en = 1'h0;
      passive_mode = 1'h1;
      tick(2);
      chk(loc_flags.crit, 1'h1);
      oam_en = 1'h1;
      n = peer_u.cnt[0];
      tick(100);
      chk(peer_u.cnt[0], n);
      peer_u.info_en = 1'h1;
      for (i = 0; i < 100 && !session_up; i++) tick(1);
      tick(30);
      chk({session_up, peer_u.cnt[0] > n}, 2'h3);
      lb_try(1'h1);
      $display("%0t passive done", $time);
   endtask
   task automatic finish_test();
      $display("compares %0d n_mismatch %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   // reset for ten cycles, then the scenarios in turn
   initial begin
      tick(10);
      rst_b = 1'h1;
      tick(2);
      t_session();
      t_events();
      t_flags();
      t_loop();
      t_down();
      finish_test();
   end
endmodule
